/* File: verilog/cfus_pkg.sv */
`default_nettype none
package cfus_pkg;
    // ----------------------------------------------------------------
    // channel configuration word
    // ----------------------------------------------------------------
    localparam int          NCH      = 6;
    localparam int          NFILT    = 6;
    localparam int          FILT_LSB = 0;
    localparam int          FILT_W   = 3;
    localparam int          LEAD_BIT = 4;
    localparam logic [15:0] CFG_RST  = 16'h0000;
    localparam logic [2:0]  LAST_CH  = 3'h5;
    localparam logic [2:0]  LAST_FILT = 3'h5;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int MS_NS         = 1000000;
    localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
    localparam int PER_W         = 10;

    // update periods in ms, index = filter code (ascending frequency)
    localparam logic [5:0][9:0] UPD_SHORT_MS = {10'h004, 10'h012, 10'h035,
                                                10'h03E, 10'h066, 10'h0F2};
    localparam logic [5:0][9:0] UPD_LONG_MS  = {10'h00A, 10'h044, 10'h0D0,
                                                10'h0F4, 10'h194, 10'h3C4};
    // digital filter cut-off in Hz
    localparam logic [5:0][6:0] CUTOFF_HZ    = {7'h6D, 7'h0E, 7'h05,
                                                7'h04, 7'h02, 7'h01};

    // ----------------------------------------------------------------
    // input image
    // ----------------------------------------------------------------
    localparam int IMG_STAT  = 6;
    localparam int IMG_RANGE = 7;
    localparam int HI_LSB    = 8;

    typedef enum logic [1:0] {
        CH_IDLE = 2'b00,
        CH_CONV = 2'b01,
        CH_HOLD = 2'b11
    } cfus_ch_state_e;
endpackage
`default_nettype wire

/* File: verilog/cfus_chan_if.sv */
`default_nettype none
interface cfus_chan_if;
    logic       start;
    logic       run;
    logic [9:0] period_ms;
    logic       done;
    logic       ready;
    modport top  (output start, run, period_ms, input  done, ready);
    modport chan (input  start, run, period_ms, output done, ready);
endinterface
`default_nettype wire

/* File: verilog/cfus_chan.sv */
`default_nettype none
module cfus_chan (
    input  wire logic    clock_i,
    input  wire logic    arst_n_i,
    input  wire logic    ms_tick_i,
    cfus_chan_if.chan    ch
);
    cfus_pkg::cfus_ch_state_e state_q;
    logic [9:0]               cnt_q;

    // ----------------------------------------------------------------
    // per-channel conversion timer
    // ----------------------------------------------------------------
    assign ch.done  = (state_q == cfus_pkg::CH_CONV) && ms_tick_i
                      && (cnt_q == ch.period_ms - 10'h001);
    assign ch.ready = (state_q != cfus_pkg::CH_CONV);

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= cfus_pkg::CH_IDLE;
        end else begin
            unique case (state_q)
                cfus_pkg::CH_IDLE,
                cfus_pkg::CH_HOLD: begin
                    if (ch.start) begin
                        state_q <= ch.run ? cfus_pkg::CH_CONV : cfus_pkg::CH_IDLE;
                    end
                end
                cfus_pkg::CH_CONV: begin
                    if (ch.done) begin
                        state_q <= cfus_pkg::CH_HOLD;
                    end
                end
                default: state_q <= cfus_pkg::CH_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q <= 10'h000;
        end else if (state_q != cfus_pkg::CH_CONV) begin
            cnt_q <= 10'h000;
        end else if (ms_tick_i) begin
            cnt_q <= cnt_q + 10'h001;
        end
    end

    period_count_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        $rose(state_q == cfus_pkg::CH_HOLD) |-> $past(cnt_q) == ch.period_ms - 10'h001)
        else $error("channel finished at wrong ms count");
endmodule // cfus_chan
`default_nettype wire

/* File: verilog/cfus_top.sv */
// Notes on behaviour
// - each channel has its own three-bit filter code in config bits 2..0.
// - lead compensation off: periods 242, 102, 62, 53, 18, 4 ms.
// - lead compensation on: periods 964, 404, 244, 208, 68, 10 ms.
// - cut-off 1, 2, 4, 5, 14, 109 Hz follows the filter code.
// - channels convert together; module scan lasts as long as slowest channel.
// - lead compensation on after reset; one channel per scan measures lead, plus any channel with a forced measurement pending.
// - lead-measured channel advances round robin over enabled channels.
// - data word refreshed each scan, held while a config change is pending.
// - image words 0..5 carry channel data; valid only if enabled, no error.
// - image words 6 and 7 carry status; meaningful only for enabled channels.
// - bit 4 clear means cyclic lead measurement; 0 then 1 forces one.
// - run entry or any config write forces lead compensation on that channel.
`default_nettype none
module cfus_top #(
    parameter int unsigned MS_CYCLES = cfus_pkg::MS_CYCLES
) (
    input  wire logic             clock_i,
    input  wire logic             arst_n_i,
    input  wire logic             run_i,
    input  wire logic [5:0]       chan_en_i,
    input  wire logic             cfg_wr_i,
    input  wire logic [2:0]       cfg_chan_i,
    input  wire logic [15:0]      cfg_word_i,
    input  wire logic [5:0][15:0] adc_data_i,
    input  wire logic [5:0]       adc_err_i,
    input  wire logic [5:0]       open_i,
    input  wire logic [5:0]       over_i,
    input  wire logic [5:0]       under_i,
    output logic      [7:0][15:0] image_o,
    output logic      [5:0]       lead_meas_o,
    output logic      [5:0]       chan_conv_o,
    output logic      [5:0][6:0]  cutoff_hz_o,
    output logic      [5:0]       cfg_err_o,
    output logic                  scan_done_o
);
    logic [15:0]       div_q;
    logic              ms_tick;
    logic [5:0][15:0]  cfg_q;
    logic [5:0][15:0]  data_q;
    logic [5:0][9:0]   per_q;
    logic [5:0]        busy_q;
    logic [5:0]        pend_q;
    logic [5:0]        lead_q;
    logic [2:0]        ptr_q;
    logic              run_q;
    logic              scan_go_q;
    logic [5:0]        chdone;
    logic [5:0]        ready;
    logic [5:0]        crun;
    logic [5:0]        stat;

    cfus_chan_if ch_if [cfus_pkg::NCH] ();

    function automatic logic [2:0] nxt_chan(input logic [2:0] p, input logic [5:0] en);
        logic [2:0] r;
        logic [2:0] c;
        logic       hit;
        r   = p;
        c   = p;
        hit = 1'b0;
        for (int i = 0; i < cfus_pkg::NCH; i++) begin
            c = (c == cfus_pkg::LAST_CH) ? 3'h0 : c + 3'h1;
            if (en[c] && !hit) begin
                r   = c;
                hit = 1'b1;
            end
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // millisecond enable
    // ----------------------------------------------------------------
    assign ms_tick = (div_q == 16'(MS_CYCLES - 1));

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div_q <= 16'h0000;
        end else begin
            div_q <= ms_tick ? 16'h0000 : div_q + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // channel timers
    // ----------------------------------------------------------------
    for (genvar g = 0; g < cfus_pkg::NCH; g++) begin : g_ch
        logic [2:0] code;
        assign code                = cfg_q[g][cfus_pkg::FILT_LSB +: cfus_pkg::FILT_W];
        assign cfg_err_o[g]        = code > cfus_pkg::LAST_FILT;
        assign crun[g]             = chan_en_i[g] && !cfg_err_o[g];
        assign ch_if[g].start      = scan_go_q;
        assign ch_if[g].run        = crun[g];
        assign ch_if[g].period_ms  = per_q[g];
        assign chdone[g]           = ch_if[g].done;
        assign ready[g]            = ch_if[g].ready;

        cfus_chan u_chan (
            .clock_i   (clock_i),
            .arst_n_i  (arst_n_i),
            .ms_tick_i (ms_tick),
            .ch        (ch_if[g])
        );
    end

    assign chan_conv_o = ~ready;
    assign scan_done_o = scan_go_q;

    // ----------------------------------------------------------------
    // configuration store
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cfg_q <= {cfus_pkg::NCH{cfus_pkg::CFG_RST}};
        end else if (cfg_wr_i && cfg_chan_i <= cfus_pkg::LAST_CH) begin
            cfg_q[cfg_chan_i] <= cfg_word_i;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cutoff_hz_o <= '0;
        end else begin
            for (int i = 0; i < cfus_pkg::NCH; i++) begin
                cutoff_hz_o[i] <= cfg_err_o[i] ? 7'h00 : cfus_pkg::CUTOFF_HZ[cfg_q[i][2:0]];
            end
        end
    end

    // ----------------------------------------------------------------
    // module scan and lead-wire scheduling
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            scan_go_q <= 1'b0;
        end else begin
            scan_go_q <= (&ready) && !scan_go_q;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ptr_q  <= 3'h0;
            lead_q <= 6'h00;
            per_q  <= '0;
        end else if (scan_go_q) begin
            ptr_q <= nxt_chan(ptr_q, chan_en_i);
            for (int i = 0; i < cfus_pkg::NCH; i++) begin
                lead_q[i] <= (ptr_q == 3'(i) && !cfg_q[i][cfus_pkg::LEAD_BIT] && crun[i])
                             || pend_q[i];
                if (cfg_err_o[i]) begin
                    per_q[i] <= 10'h001;
                end else if (!cfg_q[i][cfus_pkg::LEAD_BIT] || pend_q[i]) begin
                    per_q[i] <= cfus_pkg::UPD_LONG_MS[cfg_q[i][2:0]];
                end else begin
                    per_q[i] <= cfus_pkg::UPD_SHORT_MS[cfg_q[i][2:0]];
                end
            end
        end
    end

    assign lead_meas_o = lead_q & chan_conv_o;

    // forced lead measurement; a new request wins over the scan-start clear
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            run_q  <= 1'b0;
            pend_q <= 6'h00;
        end else begin
            run_q <= run_i;
            for (int i = 0; i < cfus_pkg::NCH; i++) begin
                if ((run_i && !run_q) || (cfg_wr_i && cfg_chan_i == 3'(i))) begin
                    pend_q[i] <= 1'b1;
                end else if (scan_go_q) begin
                    pend_q[i] <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // data words and image
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            busy_q <= 6'h00;
            data_q <= '0;
        end else begin
            for (int i = 0; i < cfus_pkg::NCH; i++) begin
                if (chdone[i] && !busy_q[i]) begin
                    data_q[i] <= adc_data_i[i];
                end
                if (cfg_wr_i && cfg_chan_i == 3'(i)) begin
                    busy_q[i] <= 1'b1;
                end else if (chdone[i]) begin
                    busy_q[i] <= 1'b0;
                end
            end
        end
    end

    assign stat = adc_err_i | open_i | over_i | under_i | busy_q | cfg_err_o;

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            image_o <= '0;
        end else begin
            for (int i = 0; i < cfus_pkg::NCH; i++) begin
                image_o[i] <= data_q[i];
            end
            image_o[cfus_pkg::IMG_STAT]  <= {2'h0, open_i, 2'h0, stat};
            image_o[cfus_pkg::IMG_RANGE] <= {2'h0, over_i, 2'h0, under_i};
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    filter_error_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        cfg_err_o[0] == (cfg_q[0][2:0] > 3'h5))
        else $error("filter code error flag wrong");

    cutoff_fast_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        cfg_q[1][2:0] == 3'h5 |=> cutoff_hz_o[1] == 7'h6D)
        else $error("cut-off for fastest filter wrong");

    short_period_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        scan_go_q && cfg_q[0][4] && !pend_q[0] && cfg_q[0][2:0] == 3'h5
        |=> per_q[0] == 10'h004)
        else $error("short period wrong");

    long_period_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        scan_go_q && !cfg_q[2][4] && cfg_q[2][2:0] == 3'h5 |=> per_q[2] == 10'h00A)
        else $error("long period wrong");

    scan_slowest_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        scan_go_q |-> $past(ready) == 6'h3F && !$past(scan_go_q))
        else $error("scan restarted while a channel converted");

    one_cyclic_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        scan_go_q |=> $onehot0(lead_q & ~$past(pend_q)))
        else $error("more than one cyclic lead channel");

    ptr_enabled_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        scan_go_q && chan_en_i != 6'h00 ##1 $stable(chan_en_i) |-> chan_en_i[ptr_q])
        else $error("lead pointer on a disabled channel");

    hold_busy_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        chdone[0] && busy_q[0] |=> data_q[0] == $past(data_q[0]))
        else $error("data updated during config change");

    refresh_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        chdone[0] && !busy_q[0] |=> data_q[0] == $past(adc_data_i[0]))
        else $error("data word not refreshed");

    force_run_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        run_i && !run_q |=> pend_q == 6'h3F)
        else $error("run entry did not force lead compensation");

    image_data_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        ##1 image_o[5] == $past(data_q[5]))
        else $error("image data word mismatch");

    image_stat_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        ##1 image_o[6][5:0] == $past(stat) && image_o[7][13:8] == $past(over_i))
        else $error("image status word mismatch");
endmodule // cfus_top
`default_nettype wire

/* File: bench/cfus_ctrl_model.sv */
`default_nettype none
module cfus_ctrl_model (
    input  wire logic             clock_i,
    input  wire logic [7:0][15:0] image_i,
    input  wire logic [5:0]       chan_en_i,
    output logic                  run_o,
    output logic                  cfg_wr_o,
    output logic      [2:0]       cfg_chan_o,
    output logic      [15:0]      cfg_word_o,
    output logic      [5:0]       valid_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------------------
    // controller side: configuration writes and run mode
    // ------------------------------------------------------------
    initial begin
        run_o      = 1'b0;
        cfg_wr_o   = 1'b0;
        cfg_chan_o = 3'h7;
        cfg_word_o = 16'h0000;
    end
    // whole word per one-cycle strobe; idle lines show junk
    task automatic write_cfg(input logic [2:0] ch, input logic [15:0] word);
        @(posedge clock_i);
        cfg_wr_o   <= 1'b1;
        cfg_chan_o <= ch;
        cfg_word_o <= word;
        @(posedge clock_i);
        cfg_wr_o   <= 1'b0;
        cfg_chan_o <= 3'h7;
        cfg_word_o <= ~word;
    endtask
    task automatic set_run(input logic lvl);
        @(posedge clock_i);
        run_o <= lvl;
    endtask
    // data trusted only for enabled channel with no status flag
    always_comb valid_o = chan_en_i & ~image_i[6][5:0];
endmodule // cfus_ctrl_model
`default_nettype wire

/* File: bench/channel_filter_update_scheduler_tb.sv */
`default_nettype none
module channel_filter_update_scheduler_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int M = 4;
    localparam int CUT [8] = '{1, 2, 4, 5, 14, 109, 0, 0};
    logic             clock_i, arst_n_i, run_i, cfg_wr_i, scan_done_o;
    logic [2:0]       cfg_chan_i;
    logic [15:0]      cfg_word_i;
    logic [5:0]       chan_en_i, adc_err_i, open_i, over_i, under_i, valid;
    logic [5:0]       lead_meas_o, chan_conv_o, cfg_err_o, prev;
    logic [5:0][15:0] adc_data_i;
    logic [5:0][6:0]  cutoff_hz_o;
    logic [7:0][15:0] image_o;
    logic             ld;
    int               errors = 0, compares = 0, n;

    cfus_top #(.MS_CYCLES(M)) uut (.clock_i(clock_i), .arst_n_i(arst_n_i), .run_i(run_i),
        .chan_en_i(chan_en_i), .cfg_wr_i(cfg_wr_i), .cfg_chan_i(cfg_chan_i),
        .cfg_word_i(cfg_word_i), .adc_data_i(adc_data_i), .adc_err_i(adc_err_i),
        .open_i(open_i), .over_i(over_i), .under_i(under_i), .image_o(image_o),
        .lead_meas_o(lead_meas_o), .chan_conv_o(chan_conv_o), .cutoff_hz_o(cutoff_hz_o),
        .cfg_err_o(cfg_err_o), .scan_done_o(scan_done_o));
    cfus_ctrl_model ctrl (.clock_i(clock_i), .image_i(image_o), .chan_en_i(chan_en_i),
        .run_o(run_i), .cfg_wr_o(cfg_wr_i), .cfg_chan_o(cfg_chan_i),
        .cfg_word_o(cfg_word_i), .valid_o(valid));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clock_i);
    endtask
    // returns cycles until the next scan boundary
    task automatic wait_scan(output int k);
        k = 0;
        do begin
            @(posedge clock_i);
            k++;
        end while (scan_done_o !== 1'b1 && k < 5000);
        check("scan_seen", 16'(scan_done_o), 16'h0001);
    endtask
    // length of the next full conversion of a channel, lead flag inside it
    task automatic conv_len(input int ch, output int k, output logic l);
        k = 0;
        while (chan_conv_o[ch] === 1'b1 && k < 5000) begin
            @(posedge clock_i);
            k++;
        end
        k = 0;
        while (chan_conv_o[ch] !== 1'b1 && k < 5000) begin
            @(posedge clock_i);
            k++;
        end
        l = lead_meas_o[ch];
        k = 0;
        while (chan_conv_o[ch] === 1'b1 && k < 5000) begin
            @(posedge clock_i);
            k++;
        end
    endtask
    task automatic rng(input string w, input int k, input int p);
        check(w, 16'(k >= (p - 1) * M && k <= p * M + 1), 16'h0001);
    endtask
    task automatic wrap_up;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        cyc(3);
        check("cfg_err", 16'(cfg_err_o), 16'h0000);
        check("cutoff0", 16'(cutoff_hz_o[0]), 16'h0001);
        check("status", image_o[6], 16'h0000);
        conv_len(0, n, ld);
        rng("long_964", n, 964);
        check("lead0", 16'(ld), 16'h0001);
    endtask
    task automatic t_codes;
        for (int c = 0; c < 8; c++) begin
            ctrl.write_cfg(3'h1, 16'(c));
            cyc(1);
            check("cfg_err1", 16'(cfg_err_o[1]), 16'(c > 5));
            cyc(1);
            check("cutoff1", 16'(cutoff_hz_o[1]), 16'(CUT[c]));
        end
        ctrl.write_cfg(3'h1, 16'h0015);
        ctrl.write_cfg(3'h6, 16'h0007);
        cyc(2);
        check("cfg_ignored", 16'(cfg_err_o), 16'h0000);
    endtask
    task automatic t_periods;
        chan_en_i <= 6'h03;
        ctrl.write_cfg(3'h0, 16'h0015);
        ctrl.write_cfg(3'h1, 16'h0013);
        wait_scan(n);
        wait_scan(n);
        conv_len(0, n, ld);
        rng("short_4", n, 4);
        check("no_lead", 16'(ld), 16'h0000);
        wait_scan(n);
        wait_scan(n);
        // scan length minus the boundary pulse and restart cycles
        rng("scan_53", n - 2, 53);
    endtask
    task automatic t_robin;
        chan_en_i <= 6'h05;
        ctrl.write_cfg(3'h0, 16'h0005);
        ctrl.write_cfg(3'h2, 16'h0005);
        wait_scan(n);
        wait_scan(n);
        prev = 6'h00;
        for (int s = 0; s < 4; s++) begin
            wait_scan(n);
            cyc(2);
            check("lead_one", 16'(lead_meas_o == 6'h01 || lead_meas_o == 6'h04), 16'h1);
            check("lead_move", 16'(lead_meas_o != prev), 16'h0001);
            prev = lead_meas_o;
        end
    endtask
    task automatic t_data;
        chan_en_i <= 6'h01;
        adc_data_i[0] <= 16'h1234;
        adc_data_i[1] <= 16'h5555;
        ctrl.write_cfg(3'h0, 16'h0015);
        repeat (3) wait_scan(n);
        check("data0", image_o[0], 16'h1234);
        check("valid0", 16'(valid[0]), 16'h0001);
        adc_data_i[0] <= 16'hABCD;
        ctrl.write_cfg(3'h0, 16'h0015);
        cyc(2);
        check("busy0", 16'(image_o[6][0]), 16'h0001);
        wait_scan(n);
        check("held0", image_o[0], 16'h1234);
        wait_scan(n);
        check("new0", image_o[0], 16'hABCD);
        check("disabled1", image_o[1], 16'h0000);
    endtask
    task automatic t_run;
        chan_en_i <= 6'h03;
        ctrl.write_cfg(3'h1, 16'h0015);
        repeat (2) wait_scan(n);
        ctrl.set_run(1'b1);
        wait_scan(n);
        cyc(2);
        check("run_lead", 16'(lead_meas_o), 16'h0003);
        ctrl.write_cfg(3'h0, 16'h0005);
        ctrl.write_cfg(3'h0, 16'h0015);
        wait_scan(n);
        cyc(2);
        check("forced_lead", 16'(lead_meas_o), 16'h0001);
    endtask
    task automatic t_status;
        open_i    <= 6'h04;
        over_i    <= 6'h08;
        under_i   <= 6'h10;
        adc_err_i <= 6'h20;
        cyc(4);
        check("word6", image_o[6], 16'h043C);
        check("word7", image_o[7], 16'h0810);
    endtask

    // ------------------------------------------------------------
    // clock, reset, sequence, watchdog
    // ------------------------------------------------------------
    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end
    initial begin
        arst_n_i   = 1'b0;
        chan_en_i  = 6'h01;
        adc_data_i = '0;
        adc_err_i  = 6'h00;
        open_i     = 6'h00;
        over_i     = 6'h00;
        under_i    = 6'h00;
        cyc(4);
        arst_n_i <= 1'b1;
        t_reset();
        t_codes();
        t_periods();
        t_robin();
        t_data();
        t_run();
        t_status();
        wrap_up();
    end
    initial begin
        cyc(60000);
        errors++;
        wrap_up();
    end
endmodule // channel_filter_update_scheduler_tb
`default_nettype wire
